//--- core/pscs_pkg.sv
// Behaviour
// R1 - Four-bit code picks one fixed frequency triple
// R2 - Latch bit0 at supply; pin copies crystal
// R3 - First crystal copy drive 1x/2x, default 1x
// R4 - Type 1: power-good low latches, enables clocks
// R5 - After first power-good low, pin ignored
// R6 - Type 0: power-good pin is crystal copy
// R7 - Latch type strap; pin becomes graphics clock
// R8 - Latch multiplier; 0 four, 1 six times
// R9 - True host pin push-pull or open-drain
// R10 - Complement host pin follows same strap
// R11 - Board pulls unused power-good pin low
// R12 - Latch bit1; pin becomes free bus clock
// R13 - Latch bit3; pin becomes usb clock
// R14 - Latch bit2; pin becomes io-chip clock
// R15 - Straps held, clocks off, pins undriven
package pscs_pkg;
	// Register byte addresses
	localparam logic [7:0] PSCS_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PSCS_ADDR_STAT = 8'h04;
	localparam logic [7:0] PSCS_ADDR_FREQ = 8'h08;
	// Control fields and reset value
	localparam int PSCS_CTRL_W = 2;
	localparam int PSCS_CTRL_REF_X2 = 0;
	localparam int PSCS_CTRL_IO_48 = 1;
	localparam logic [1:0] PSCS_CTRL_RST = 2'h0;
	// Status field positions
	localparam int PSCS_ST_MODE = 4;
	localparam int PSCS_ST_MULT = 5;
	localparam int PSCS_ST_LATCHED = 6;
	localparam int PSCS_ST_RUN = 7;
	// Frequency word fields, tenths of MHz
	localparam int PSCS_FQ_GFX = 12;
	localparam int PSCS_FQ_BUS = 22;
	// Synchroniser lanes
	localparam int PSCS_SY_W = 9;
	localparam int PSCS_SY_SUP = 0;
	localparam int PSCS_SY_PG = 1;
	localparam int PSCS_SY_XT = 2;
	localparam int PSCS_SY_FS = 3;
	localparam int PSCS_SY_PT = 7;
	localparam int PSCS_SY_MS = 8;
	localparam logic [8:0] PSCS_SY_RST = 9'h000;
	// Divider width for the clock enables
	localparam int PSCS_DIV_W = 3;
	localparam logic [2:0] PSCS_DIV_ONE = 3'h1;
	localparam logic [2:0] PSCS_DIV_ALL = 3'h7;
	localparam logic [1:0] PSCS_DIV_LOW = 2'h3;
	// Frequency triple per code, tenths of MHz
	localparam logic [11:0] PSCS_HOST [16] = '{12'd1009, 12'd1000, 12'd1339,
		12'd1333, 12'd1100, 12'd1452, 12'd1800, 12'd1984, 12'd2009, 12'd2000,
		12'd1669, 12'd1666, 12'd1000, 12'd1333, 12'd2000, 12'd1666};
	localparam logic [9:0] PSCS_GFX [16] = '{10'd673, 10'd667, 10'd669,
		10'd667, 10'd733, 10'd726, 10'd720, 10'd717, 10'd669, 10'd667,
		10'd668, 10'd666, 10'd667, 10'd667, 10'd667, 10'd666};
	localparam logic [8:0] PSCS_BUS [16] = '{9'd336, 9'd333, 9'd335, 9'd333,
		9'd367, 9'd363, 9'd360, 9'd358, 9'd335, 9'd333, 9'd334, 9'd333,
		9'd333, 9'd333, 9'd333, 9'd333};
	// Latched strap set
	typedef struct packed {
		logic [3:0] code;
		logic mode;
		logic mult;
	} pscs_straps_t;
	localparam pscs_straps_t PSCS_STRAPS_RST = '0;
	// Power-on sequence
	typedef enum logic [1:0] {ST_POWER, ST_PGWAIT, ST_RUN} pscs_state_t;
endpackage

//--- core/pscs_top.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pscs_top import pscs_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_ok,
	input wire logic crystal_input,
	input wire logic freq_select_bit0,
	output logic crystal_copy_out_a,
	output logic crystal_copy_out_a_oe,
	input wire logic freq_select_bit1,
	output logic bus_clock_free,
	output logic bus_clock_free_oe,
	input wire logic freq_select_bit2,
	output logic io_chip_clock_out,
	output logic io_chip_clock_out_oe,
	input wire logic freq_select_bit3,
	output logic usb_clock_out,
	output logic usb_clock_out_oe,
	input wire logic processor_type_strap,
	output logic graphics_clock_out_1,
	output logic graphics_clock_out_1_oe,
	input wire logic drive_multiplier_strap,
	output logic bus_clock_out_2,
	output logic bus_clock_out_2_oe,
	input wire logic termination_power_good_n,
	output logic crystal_copy_out_b,
	output logic crystal_copy_out_b_oe,
	output logic host_clock_true,
	output logic host_clock_true_oe,
	output logic host_clock_comp,
	output logic host_clock_comp_oe,
	output logic ref_double_drive,
	output logic host_current_six
);
	logic [PSCS_SY_W-1:0] sy1_q; // First stage, read only by second
	logic [PSCS_SY_W-1:0] sy2_q; // Safe pin levels
	logic [PSCS_SY_W-1:0] pins; // Raw pin vector
	pscs_state_t st_q, st_d; // Power-on sequence state
	pscs_straps_t sp_q, sp_d; // Latched straps
	pscs_straps_t sp_pin; // Straps as seen on the pins now
	logic [PSCS_CTRL_W-1:0] ctrl_q, ctrl_d; // Software control
	logic [31:0] rd_q, rd_d; // Read data register
	logic [31:0] rd_mux; // Selected register word
	logic [31:0] freq_q, freq_d; // Decoded frequency triple
	logic [PSCS_DIV_W-1:0] div_q, div_d; // Rate divider
	logic [6:0] ck_q, ck_d; // Clock toggles and crystal copies
	logic en2, en4, en8; // One-cycle rate enables
	logic run; // Clocks enabled
	logic hit; // Address is mapped
	logic wr_acc; // Write takes effect now

	// Gather the pins that come from outside the clock domain
	assign pins = {drive_multiplier_strap, processor_type_strap, freq_select_bit3,
		freq_select_bit2, freq_select_bit1, freq_select_bit0, crystal_input,
		termination_power_good_n, supply_ok};

	// Two-flop synchroniser for every pin input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q <= PSCS_SY_RST;
			sy2_q <= PSCS_SY_RST;
		end else begin
			sy1_q <= pins;
			sy2_q <= sy1_q;
		end
	end

	// Straps as they stand on the shared pins
	always_comb begin
		sp_pin.code = sy2_q[PSCS_SY_FS +: 4];
		sp_pin.mode = sy2_q[PSCS_SY_PT];
		sp_pin.mult = sy2_q[PSCS_SY_MS];
	end

	// Power-on sequence and strap latching
	always_comb begin
		st_d = st_q;
		sp_d = sp_q;
		case (st_q)
			ST_POWER: begin
				// Supply crossed threshold: take every strap once
				if (sy2_q[PSCS_SY_SUP]) begin
					sp_d = sp_pin; // [R2] [R7] [R8] [R12] [R13] [R14]
					st_d = sp_pin.mode ? ST_PGWAIT : ST_RUN; // [R4] [R6]
				end
			end
			ST_PGWAIT: begin
				// Power-good low re-takes code and multiplier, then clocks run
				if (!sy2_q[PSCS_SY_PG]) begin
					sp_d.code = sp_pin.code; // [R4]
					sp_d.mult = sp_pin.mult; // [R4]
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				// Held until the next power-on; power-good no longer looked at
				st_d = ST_RUN; // [R5] [R15]
			end
			default: begin
				st_d = ST_POWER;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_POWER;
			sp_q <= PSCS_STRAPS_RST;
		end else begin
			st_q <= st_d;
			sp_q <= sp_d;
		end
	end

	assign run = (st_q == ST_RUN);

	// Rate enables from one divider; no second clock anywhere
	assign en2 = div_q[0];
	assign en4 = (div_q[1:0] == PSCS_DIV_LOW);
	assign en8 = (div_q == PSCS_DIV_ALL);

	// Output clock toggles: 0 host, 1 graphics, 2 bus, 3 usb, 4 io, 5/6 crystal
	always_comb begin
		div_d = div_q + PSCS_DIV_ONE;
		ck_d = ck_q;
		if (run) begin
			ck_d[0] = ~ck_q[0];
			if (en2) ck_d[1] = ~ck_q[1];
			if (en4) ck_d[2] = ~ck_q[2];
			if (en4) ck_d[3] = ~ck_q[3]; // [R13]
			// Io-chip clock runs at the usb rate or half of it
			if (ctrl_q[PSCS_CTRL_IO_48] ? en4 : en8) ck_d[4] = ~ck_q[4]; // [R14]
			ck_d[5] = sy2_q[PSCS_SY_XT]; // [R2]
			ck_d[6] = sy2_q[PSCS_SY_XT]; // [R6]
		end else begin
			// Clocks parked low until the sequence reaches ST_RUN
			ck_d = '0; // [R15]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
			ck_q <= '0;
		end else begin
			div_q <= div_d;
			ck_q <= ck_d;
		end
	end

	// Shared pins turn into outputs only once clocks are enabled
	assign crystal_copy_out_a = ck_q[5];
	assign crystal_copy_out_a_oe = run; // [R2] [R15]
	assign bus_clock_free = ck_q[2];
	assign bus_clock_free_oe = run; // [R12]
	assign io_chip_clock_out = ck_q[4];
	assign io_chip_clock_out_oe = run; // [R14]
	assign usb_clock_out = ck_q[3];
	assign usb_clock_out_oe = run; // [R13]
	assign graphics_clock_out_1 = ck_q[1];
	assign graphics_clock_out_1_oe = run; // [R7]
	assign bus_clock_out_2 = ck_q[2];
	assign bus_clock_out_2_oe = run; // [R8]
	// Second crystal copy only when power-good is disabled
	assign crystal_copy_out_b = ck_q[6];
	assign crystal_copy_out_b_oe = run && !sp_q.mode; // [R6]

	// Host pair: push-pull in type 1, open-drain pull-low in type 0
	assign host_clock_true = sp_q.mode ? ck_q[0] : 1'b0; // [R9]
	assign host_clock_true_oe = run && (sp_q.mode || !ck_q[0]); // [R9]
	assign host_clock_comp = sp_q.mode ? !ck_q[0] : 1'b0; // [R10]
	assign host_clock_comp_oe = run && (sp_q.mode || ck_q[0]); // [R10]

	// Drive settings for the analog buffers
	assign ref_double_drive = ctrl_q[PSCS_CTRL_REF_X2]; // [R3]
	assign host_current_six = sp_q.mult; // [R8]

	// Frequency decode of the latched code, registered for read-back
	always_comb begin
		freq_d = '0;
		freq_d[PSCS_FQ_GFX-1:0] = PSCS_HOST[sp_q.code]; // [R1]
		freq_d[PSCS_FQ_BUS-1:PSCS_FQ_GFX] = PSCS_GFX[sp_q.code]; // [R1]
		freq_d[PSCS_FQ_BUS+8:PSCS_FQ_BUS] = PSCS_BUS[sp_q.code]; // [R1]
	end

	// APB: zero wait states, unmapped addresses answer with an error
	assign hit = (paddr == PSCS_ADDR_CTRL) || (paddr == PSCS_ADDR_STAT)
		|| (paddr == PSCS_ADDR_FREQ);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign wr_acc = psel && penable && pwrite && (paddr == PSCS_ADDR_CTRL);
	assign prdata = rd_q;

	// Read mux; status shows the sequence, not just stored bits
	always_comb begin
		rd_mux = '0;
		case (paddr)
			PSCS_ADDR_CTRL: rd_mux[PSCS_CTRL_W-1:0] = ctrl_q;
			PSCS_ADDR_STAT: begin
				rd_mux[PSCS_ST_MODE-1:0] = sp_q.code;
				rd_mux[PSCS_ST_MODE] = sp_q.mode;
				rd_mux[PSCS_ST_MULT] = sp_q.mult;
				rd_mux[PSCS_ST_LATCHED] = (st_q != ST_POWER);
				rd_mux[PSCS_ST_RUN] = run;
			end
			PSCS_ADDR_FREQ: rd_mux = freq_q;
			default: rd_mux = '0;
		endcase
	end

	// Control write in the access cycle, read capture in the setup cycle
	always_comb begin
		ctrl_d = ctrl_q;
		rd_d = rd_q;
		if (wr_acc) ctrl_d = pwdata[PSCS_CTRL_W-1:0]; // [R3]
		if (psel && !penable) rd_d = pwrite ? '0 : rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= PSCS_CTRL_RST; // [R3]
			rd_q <= '0;
			freq_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			rd_q <= rd_d;
			freq_q <= freq_d;
		end
	end

	// Checks
	property p_decode;
		@(posedge pclk) disable iff (!presetn)
		run |=> freq_q[PSCS_FQ_GFX-1:0] == PSCS_HOST[$past(sp_q.code)];
	endproperty
	a_decode: assert property (p_decode) else $error("bad host decode"); // [R1]

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		run |=> $stable(sp_q) && run;
	endproperty
	a_hold: assert property (p_hold) else $error("straps moved"); // [R15]

	property p_pg_latch;
		@(posedge pclk) disable iff (!presetn)
		(st_q == ST_PGWAIT) && !sy2_q[PSCS_SY_PG] |=> run
			&& sp_q.code == $past(sy2_q[PSCS_SY_FS +: 4]);
	endproperty
	a_pg_latch: assert property (p_pg_latch) else $error("no pg latch"); // [R4]

	property p_pg_ignored;
		@(posedge pclk) disable iff (!presetn)
		run && $fell(sy2_q[PSCS_SY_PG]) |-> ##1 run ##1 $stable(sp_q);
	endproperty
	a_pg_ignored: assert property (p_pg_ignored) else $error("pg not ignored"); // [R5]

	property p_undriven;
		@(posedge pclk) disable iff (!presetn)
		!run |-> !crystal_copy_out_a_oe && !graphics_clock_out_1_oe
			&& !usb_clock_out_oe && !host_clock_true_oe && !crystal_copy_out_b_oe;
	endproperty
	a_undriven: assert property (p_undriven) else $error("early drive"); // [R15]

	property p_ref_b;
		@(posedge pclk) disable iff (!presetn)
		run ##1 run |-> crystal_copy_out_b_oe == !sp_q.mode
			&& (sp_q.mode || crystal_copy_out_b == $past(sy2_q[PSCS_SY_XT]));
	endproperty
	a_ref_b: assert property (p_ref_b) else $error("second copy wrong"); // [R6]

	property p_ref_a;
		@(posedge pclk) disable iff (!presetn)
		run ##1 run |-> crystal_copy_out_a == $past(sy2_q[PSCS_SY_XT]);
	endproperty
	a_ref_a: assert property (p_ref_a) else $error("first copy wrong"); // [R2]

	property p_mode_b_direct;
		@(posedge pclk) disable iff (!presetn)
		(st_q == ST_POWER) && sy2_q[PSCS_SY_SUP] && !sy2_q[PSCS_SY_PT] |=> run
			&& !sp_q.mode && host_current_six == $past(sy2_q[PSCS_SY_MS]);
	endproperty
	a_mode_b_direct: assert property (p_mode_b_direct) else $error("mode b"); // [R8]

	property p_host_pp;
		@(posedge pclk) disable iff (!presetn)
		run && sp_q.mode |-> host_clock_true_oe && host_clock_comp_oe
			&& host_clock_true != host_clock_comp;
	endproperty
	a_host_pp: assert property (p_host_pp) else $error("push-pull wrong"); // [R9]

	property p_host_od;
		@(posedge pclk) disable iff (!presetn)
		run && !sp_q.mode |-> !host_clock_true && !host_clock_comp
			&& (host_clock_true_oe != host_clock_comp_oe);
	endproperty
	a_host_od: assert property (p_host_od) else $error("open-drain wrong"); // [R10]

	property p_ref_drive;
		@(posedge pclk) disable iff (!presetn)
		wr_acc |=> ref_double_drive == $past(pwdata[PSCS_CTRL_REF_X2]);
	endproperty
	a_ref_drive: assert property (p_ref_drive) else $error("drive select"); // [R3]
endmodule // pscs_top

//--- tb/pscs_board.sv
`timescale 1ns/1ps
module pscs_board import pscs_pkg::*; (
	input wire logic pclk,
	input wire pscs_straps_t want, // Resistor levels chosen by the bench
	input wire logic pg_low, // Power-good held low
	output pscs_straps_t straps,
	output logic crystal,
	output logic termination_power_good_n
);
	// Resistors only; the chip's own drive wins once it enables a pin
	assign straps = want;
	// Unused power-good is pulled to ground
	assign termination_power_good_n = ~pg_low;
	// Crystal as a free toggle; real rate does not matter here
	initial crystal = 1'b0;
	always @(posedge pclk) begin
		crystal <= ~crystal;
	end
endmodule // pscs_board

//--- tb/pscs_top_tb_top.sv
`timescale 1ns/1ps
module pscs_top_tb_top import pscs_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, supply_ok, pg_low, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic crystal_input, termination_power_good_n, e;
	pscs_straps_t want, straps;
	logic crystal_copy_out_a, crystal_copy_out_a_oe, bus_clock_free, bus_clock_free_oe;
	logic io_chip_clock_out, io_chip_clock_out_oe, usb_clock_out, usb_clock_out_oe;
	logic graphics_clock_out_1, graphics_clock_out_1_oe, bus_clock_out_2, bus_clock_out_2_oe;
	logic crystal_copy_out_b, crystal_copy_out_b_oe, host_clock_true, host_clock_true_oe;
	logic host_clock_comp, host_clock_comp_oe, ref_double_drive, host_current_six;
	logic [5:0] pin_w; // Resolved shared pins
	logic [7:0] clk_w; // Output clocks watched for their rates
	int errors, n_checks;
	// Expected rates per code, tenths of MHz
	int fh[16] = '{1009, 1000, 1339, 1333, 1100, 1452, 1800, 1984, 2009, 2000, 1669, 1666,
		1000, 1333, 2000, 1666};
	int fg[16] = '{673, 667, 669, 667, 733, 726, 720, 717, 669, 667, 668, 666, 667, 667, 667, 666};
	int fb[16] = '{336, 333, 335, 333, 367, 363, 360, 358, 335, 333, 334, 333, 333, 333, 333, 333};
	// Pin level: chip output while driven, else the board resistor
	assign pin_w[0] = crystal_copy_out_a_oe ? crystal_copy_out_a : straps.code[0];
	assign pin_w[1] = bus_clock_free_oe ? bus_clock_free : straps.code[1];
	assign pin_w[2] = io_chip_clock_out_oe ? io_chip_clock_out : straps.code[2];
	assign pin_w[3] = usb_clock_out_oe ? usb_clock_out : straps.code[3];
	assign pin_w[4] = graphics_clock_out_1_oe ? graphics_clock_out_1 : straps.mode;
	assign pin_w[5] = bus_clock_out_2_oe ? bus_clock_out_2 : straps.mult;
	// Output clock levels gathered for edge counting
	assign clk_w = {host_clock_true, graphics_clock_out_1, bus_clock_free, bus_clock_out_2,
		usb_clock_out, io_chip_clock_out, crystal_copy_out_a, crystal_copy_out_b};
	pscs_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .supply_ok, .crystal_input, .freq_select_bit0(pin_w[0]),
		.crystal_copy_out_a, .crystal_copy_out_a_oe, .freq_select_bit1(pin_w[1]),
		.bus_clock_free, .bus_clock_free_oe, .freq_select_bit2(pin_w[2]), .io_chip_clock_out,
		.io_chip_clock_out_oe, .freq_select_bit3(pin_w[3]), .usb_clock_out, .usb_clock_out_oe,
		.processor_type_strap(pin_w[4]), .graphics_clock_out_1, .graphics_clock_out_1_oe,
		.drive_multiplier_strap(pin_w[5]), .bus_clock_out_2, .bus_clock_out_2_oe,
		.termination_power_good_n, .crystal_copy_out_b, .crystal_copy_out_b_oe,
		.host_clock_true, .host_clock_true_oe, .host_clock_comp, .host_clock_comp_oe,
		.ref_double_drive, .host_current_six);
	pscs_board u_board (.pclk, .want, .pg_low, .straps, .crystal(crystal_input),
		.termination_power_good_n);
	// Reference clock, 5 ns period
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;
	// Single result compare, four-state exact
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Rising edges of each output clock but the host complement over 32 cycles; the io rate follows the control bit
	task rates(input int io_ex);
		logic [7:0] prev;
		int n [8];
		foreach (n[k]) n[k] = 0;
		prev = clk_w;
		repeat (32) begin
			@(posedge pclk);
			foreach (n[k]) if (clk_w[k] && !prev[k]) n[k]++;
			prev = clk_w;
		end
		chk("host_rate", 16, n[7]);
		chk("gfx_rate", 8, n[6]);
		chk("bus_free_rate", 4, n[5]);
		chk("bus_2_rate", 4, n[4]);
		chk("usb_rate", 4, n[3]);
		chk("io_rate", io_ex, n[2]);
		chk("copy_a_rate", 16, n[1]);
		chk("copy_b_rate", 16, n[0]);
	endtask
	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Full power cycle with chosen straps; first crystal copy and graphics pins must float before supply comes up
	task pwr(input logic [3:0] c, input logic m, input logic x, input logic pg);
		@(posedge pclk);
		presetn <= 1'b0;
		supply_ok <= 1'b0;
		want <= {c, m, x};
		pg_low <= pg;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("oe_early", 0, {crystal_copy_out_a_oe, graphics_clock_out_1_oe});
		supply_ok <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
	task close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog, far beyond the expected run of about 450 cycles
	initial begin
		#100000;
		errors++;
		$display("ERROR watchdog expected finish seen timeout");
		close_out;
	end
	initial begin
		{presetn, psel, penable, pwrite, supply_ok, pg_low, paddr, pwdata} = '0;
		want = '0;
		repeat (2) @(posedge pclk);
		// Mode B, every code; power-good held low must not matter
		for (int i = 0; i < 16; i++) begin
			pwr(i[3:0], 1'b0, i[0], 1'b1);
			apb(1'b0, PSCS_ADDR_STAT, 0);
			chk("status", {24'h0, 2'h3, i[0], 1'b0, i[3:0]}, r);
			apb(1'b0, PSCS_ADDR_FREQ, 0);
			chk("freq", (fb[i] << 22) | (fg[i] << 12) | fh[i], r);
			chk("mult", i[0], host_current_six);
			chk("oe_run", 7'h7f, {crystal_copy_out_a_oe, bus_clock_free_oe, io_chip_clock_out_oe,
				usb_clock_out_oe, graphics_clock_out_1_oe, bus_clock_out_2_oe,
				crystal_copy_out_b_oe});
			chk("host_od", 1, {host_clock_true, host_clock_comp,
				host_clock_true_oe ^ host_clock_comp_oe});
		end
		$display("test codes done");
		// Mode A: wait for power-good, code and multiplier re-read at its fall
		pwr(4'h5, 1'b1, 1'b0, 1'b0);
		apb(1'b0, PSCS_ADDR_STAT, 0);
		chk("pg_wait", 8'h55, r);
		chk("oe_wait", 0, graphics_clock_out_1_oe);
		want <= {4'ha, 1'b1, 1'b1};
		repeat (4) @(posedge pclk);
		pg_low <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, PSCS_ADDR_STAT, 0);
		chk("pg_latch", 8'hfa, r);
		chk("host_pp", 7, {host_clock_true_oe, host_clock_comp_oe,
			host_clock_true ^ host_clock_comp});
		chk("ref_b_off", 0, crystal_copy_out_b_oe);
		pg_low <= 1'b0;
		repeat (6) @(posedge pclk);
		pg_low <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, PSCS_ADDR_STAT, 0);
		chk("pg_ignored", 8'hfa, r);
		$display("test power_good done");
		// Drive control register, read-only status, unmapped place
		apb(1'b0, PSCS_ADDR_CTRL, 0);
		chk("ctrl_rst", 0, r);
		chk("drive_1x", 0, ref_double_drive);
		rates(2);
		apb(1'b1, PSCS_ADDR_CTRL, 32'h3);
		apb(1'b0, PSCS_ADDR_CTRL, 0);
		chk("ctrl", 3, r);
		chk("drive_2x", 1, ref_double_drive);
		rates(4);
		apb(1'b1, PSCS_ADDR_STAT, 32'h0);
		apb(1'b0, PSCS_ADDR_STAT, 0);
		chk("stat_ro", 8'hfa, r);
		apb(1'b0, 8'h0c, 0);
		chk("slverr", 1, e);
		$display("test registers done");
		close_out;
	end
endmodule // pscs_top_tb_top
